// file: swcmd_decoder.sv
/*
 * Serial command decoder of a 16-channel low-side switch: shifts frames in
 * and responses out, decodes five commands, latches channel data and the
 * combining operation, and builds the next response.
 * Assumes shift clock and chip select are pins sampled by CLK_I, well below
 * half its rate, and diagnosis pairs come from analog fault detection.
 */
`timescale 1ns/1ps
module swcmd_decoder
    import swcmd_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SCLK_I,
    input wire logic CS_N_I,
    input wire logic SI_I,
    input wire logic PRG_I,
    input wire logic [swcmd_pkg::PAR_BITS-1:0] PAR_IN_I,
    input wire logic [swcmd_pkg::DIAG_W-1:0] DIAG_I,
    output logic [swcmd_pkg::NUM_CH-1:0] OUT_O,
    output logic SO_O,
    output logic SO_OE_O,
    output logic OP_AND_O
);
    import swcmd_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [FRAME_BITS-1:0] diag_word(input logic [DIAG_W-1:0] d,
                                                         input logic g);
        return g ? d[DIAG_W-1:FRAME_BITS] : d[FRAME_BITS-1:0];
    endfunction

    function automatic logic [BYTE_BITS-1:0] fault_byte(input logic [DIAG_W-1:0] d,
                                                        input logic g);
        logic [FRAME_BITS-1:0] w;
        logic [BYTE_BITS-1:0] f;
        w = diag_word(d, g);
        for (int k = 0; k < CH_PER_GRP; k++)
        begin
            f[k] = (w[k*DIAG_BITS +: DIAG_BITS] == DIAG_NORMAL);
        end
        return f;
    endfunction

    function automatic logic combine(input logic is_and, input logic act, input logic d);
        return is_and ? (act & d) : (act | d);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic sclk_s;
    logic cs_s;
    logic cs_n_s;
    logic si_s;
    logic prg_s;
    logic [PAR_BITS-1:0] par_s;
    logic [DIAG_W-1:0] diag_s;

    swcmd_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .d_i({SCLK_I, ~CS_N_I, SI_I, PRG_I, PAR_IN_I, DIAG_I}),
        .q_o({sclk_s, cs_s, si_s, prg_s, par_s, diag_s})
    );

    // select enters inverted so a cleared synchroniser reads as deselected,
    // otherwise reset release would fake a frame start and end
    assign cs_n_s = ~cs_s;

    logic sclk_q;
    logic cs_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    // shift edges outside a frame are ignored
    assign cs_fall = cs_q & ~cs_n_s;
    assign cs_rise = ~cs_q & cs_n_s;
    assign sclk_rise = ~sclk_q & sclk_s & ~cs_n_s;
    assign sclk_fall = sclk_q & ~sclk_s & ~cs_n_s;

    // ------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------
    logic [FRAME_BITS-1:0] rx;
    logic [FRAME_BITS-1:0] tx;
    logic [CNT_W-1:0] bit_cnt;
    swcmd_resp_type resp;
    logic resp_grp;
    logic echo_on;
    logic [NUM_CH-1:0] data;
    logic op_and;
    logic [NUM_CH-1:0] out;
    logic so;

    logic [FRAME_BITS-1:0] next_rx;
    logic [FRAME_BITS-1:0] next_tx;
    logic [CNT_W-1:0] next_bit_cnt;
    swcmd_resp_type next_resp;
    logic next_resp_grp;
    logic next_echo_on;
    logic [NUM_CH-1:0] next_data;
    logic next_op_and;
    logic [NUM_CH-1:0] next_out;
    logic next_so;

    logic [3:0] ctrl_cmd;
    logic [3:0] ctrl_grp;
    logic [BYTE_BITS-1:0] data_byte;
    logic frame_ok;
    logic grp_ok;
    logic grp_sel;
    logic [PAR_BITS-1:0] par_act;

    assign ctrl_cmd = rx[FRAME_BITS-1 -: 4];
    assign ctrl_grp = rx[BYTE_BITS +: 4];
    assign data_byte = rx[BYTE_BITS-1:0];
    // short or long frames are treated as undefined words
    assign frame_ok = (bit_cnt == FRAME_COUNT) & ~echo_on;
    assign grp_ok = (ctrl_grp == GRP_LOW_SEL) | (ctrl_grp == GRP_HIGH_SEL);
    assign grp_sel = (ctrl_grp == GRP_HIGH_SEL);
    assign par_act = prg_s ? par_s : ~par_s;

    always_comb
    begin
        next_rx = rx;
        next_tx = tx;
        next_bit_cnt = bit_cnt;
        next_resp = resp;
        next_resp_grp = resp_grp;
        next_echo_on = echo_on;
        next_data = data;
        next_op_and = op_and;

        // response of the previous command goes out in this frame
        if (cs_fall)
        begin
            next_bit_cnt = '0;
            next_echo_on = (resp == RESP_ECHO);
            case (resp)
                RESP_DIAG: next_tx = diag_word(diag_s, resp_grp);
                RESP_READ: next_tx = {par_s, fault_byte(diag_s, resp_grp)};
                RESP_ECHO: next_tx = WORD_ZERO;
                RESP_ZERO: next_tx = WORD_ZERO;
                default: next_tx = WORD_ZERO;
            endcase
        end

        if (sclk_fall)
        begin
            next_rx = {rx[FRAME_BITS-2:0], si_s};
            if (bit_cnt != COUNT_MAX)
            begin
                next_bit_cnt = bit_cnt + 5'h01;
            end
        end

        if (sclk_rise)
        begin
            next_tx = {tx[FRAME_BITS-2:0], 1'b0};
        end

        // a finished frame takes effect only here
        if (cs_rise)
        begin
            next_echo_on = 1'b0;
            next_resp = RESP_ZERO;
            next_resp_grp = grp_sel;
            if (frame_ok && grp_ok)
            begin
                case (ctrl_cmd)
                    CMD_DIAG: next_resp = RESP_DIAG;
                    CMD_READ: next_resp = RESP_READ;
                    CMD_ECHO: next_resp = RESP_ECHO;
                    CMD_OR:
                    begin
                        next_data[grp_sel*CH_PER_GRP +: CH_PER_GRP] = data_byte;
                        next_op_and = 1'b0;
                        next_resp = RESP_DIAG;
                    end
                    CMD_AND:
                    begin
                        next_data[grp_sel*CH_PER_GRP +: CH_PER_GRP] = data_byte;
                        next_op_and = 1'b1;
                        next_resp = RESP_DIAG;
                    end
                    default: next_resp = RESP_ZERO;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // channel drive and serial output
    // ------------------------------------------------------------
    // parallel inputs are combined live so PWM on them passes through
    always_comb
    begin
        for (int g = 0; g < NUM_CH / CH_PER_GRP; g++)
        begin
            for (int k = 0; k < CH_PER_GRP; k++)
            begin
                if (k < PAR_PER_GRP)
                begin
                    next_out[g*CH_PER_GRP+k] = combine(op_and, par_act[g*PAR_PER_GRP+k],
                                                       data[g*CH_PER_GRP+k]);
                end
                else
                begin
                    next_out[g*CH_PER_GRP+k] = data[g*CH_PER_GRP+k];
                end
            end
        end
        next_so = next_echo_on ? si_s : next_tx[FRAME_BITS-1];
    end

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            rx <= WORD_ZERO;
            tx <= WORD_ZERO;
            bit_cnt <= '0;
            resp <= RESP_ZERO;
            resp_grp <= 1'b0;
            echo_on <= 1'b0;
            data <= DATA_RESET;
            op_and <= OP_AND_RESET;
            out <= DATA_RESET;
            so <= 1'b0;
        end
        else
        begin
            sclk_q <= sclk_s;
            cs_q <= cs_n_s;
            rx <= next_rx;
            tx <= next_tx;
            bit_cnt <= next_bit_cnt;
            resp <= next_resp;
            resp_grp <= next_resp_grp;
            echo_on <= next_echo_on;
            data <= next_data;
            op_and <= next_op_and;
            out <= next_out;
            so <= next_so;
        end
    end

    assign OUT_O = out;
    assign SO_O = so;
    assign SO_OE_O = ~cs_q;
    assign OP_AND_O = op_and;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    a_group_data_write: assert property (
        cs_rise && frame_ok && rx[FRAME_BITS-1:BYTE_BITS] == {CMD_OR, GRP_HIGH_SEL}
        |=> data[NUM_CH-1:CH_PER_GRP] == $past(data_byte)
            && data[CH_PER_GRP-1:0] == $past(data[CH_PER_GRP-1:0]))
        else $error("group write went to the wrong channels");
    a_diag_keeps_state: assert property (
        cs_rise && ctrl_cmd == CMD_DIAG |=> $stable(data) && $stable(op_and))
        else $error("diagnosis-only changed channel state");
    a_diag_one_frame: assert property (
        cs_rise && resp == RESP_DIAG && !(frame_ok && grp_ok && ctrl_cmd == CMD_DIAG
            || frame_ok && grp_ok && (ctrl_cmd == CMD_OR || ctrl_cmd == CMD_AND))
        |=> resp != RESP_DIAG)
        else $error("diagnosis response persisted without a repeat");
    a_read_inputs: assert property (
        cs_fall && resp == RESP_READ |=> tx[FRAME_BITS-1:BYTE_BITS] == $past(par_s))
        else $error("read-back did not load parallel inputs");
    a_read_faults: assert property (
        cs_fall && resp == RESP_READ
        |=> tx[BYTE_BITS-1:0] == $past(fault_byte(diag_s, resp_grp)))
        else $error("read-back fault bits wrong");
    a_echo_loop: assert property (
        echo_on && !cs_rise |=> SO_O == $past(si_s))
        else $error("echo loop did not follow serial input");
    a_echo_then_zero: assert property (
        cs_rise && echo_on |=> resp == RESP_ZERO && $stable(data) && $stable(op_and))
        else $error("echo frame was processed");
    a_or_channel_on: assert property (
        !op_and && par_act[0] |=> OUT_O[0])
        else $error("or combine failed to switch on");
    a_and_channel_off: assert property (
        op_and && !data[0] |=> !OUT_O[0])
        else $error("and combine failed to switch off");
    a_or_after_reset: assert property (disable iff (1'b0)
        RESET_I |=> !OP_AND_O)
        else $error("combining operation not or after reset");
    a_op_held: assert property (
        !cs_rise |=> $stable(op_and))
        else $error("combining operation changed outside a frame end");
    a_undefined_zero: assert property (
        cs_rise && frame_ok && !grp_ok |=> resp == RESP_ZERO && $stable(data)
        ##1 (!cs_fall)[*1] ##0 1'b1)
        else $error("undefined word had an effect");
    a_direct_channels: assert property (
        1'b1 |=> OUT_O[CH_PER_GRP-1:PAR_PER_GRP] == $past(data[CH_PER_GRP-1:PAR_PER_GRP]))
        else $error("direct channel does not follow its data bit");
    a_sample_falling: assert property (
        sclk_fall |=> rx[0] == $past(si_s))
        else $error("serial input not sampled on falling edge");
    a_apply_on_cs: assert property (
        !cs_rise |=> $stable(data))
        else $error("channel data changed outside chip select rise");
    a_diag_response: assert property (
        cs_fall && resp == RESP_DIAG |=> tx == $past(diag_word(diag_s, resp_grp)))
        else $error("diagnosis response not loaded");

    c_echo_frame: cover property (cs_rise && echo_on);
    c_and_cmd: cover property (cs_rise && frame_ok && ctrl_cmd == CMD_AND && grp_ok);
    c_read_frame: cover property (cs_fall && resp == RESP_READ);
    c_undefined: cover property (cs_rise && frame_ok && !grp_ok);
endmodule

// file: swcmd_pkg.sv
/*
 * Shared constants and types for the serial command decoder of a
 * 16-channel low-side switch.
 * Assumes a host that acts as serial master and sends 16-bit frames.
 */
//
// Contract
// - a frame is a control byte followed by a data byte; control picks mode
// - low control nibble all low picks channels 1-8, all high picks 9-16
// - diagnosis-only returns two-bit diagnosis, ignores data, keeps outputs
// - diagnosis-only acts for one frame unless repeated in the next frame
// - read-back returns the eight parallel input levels first, outputs unchanged
// - read-back then returns one fault bit per channel, high means no fault
// - echo loops serial input to output for exactly the next frame
// - echo changes nothing; the frame after it reads all zero
// - OR command turns a parallel channel on if input or data bit is active
// - AND command turns a parallel channel on only if input and data active
// - OR is the combining operation after reset
// - combining operation holds until the opposite command arrives
// - undefined control bytes do nothing and make the next response zero
// - on output commands a high data bit is on, a low one is off
// - diagnosis, read-back and echo ignore every data bit
// - serial input sampled on falling shift clock edge, most significant first
// - a received frame is applied on the rising edge of chip select
// - the response is shifted out in the frame after the command
// - diagnosis pairs: HH normal, HL overload, LH open load, LL short to ground
package swcmd_pkg;

    // ------------------------------------------------------------
    // frame and channel layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int NUM_CH = 16;
    localparam int CH_PER_GRP = 8;
    localparam int PAR_PER_GRP = 4;
    localparam int PAR_BITS = 8;
    localparam int DIAG_BITS = 2;
    localparam int DIAG_W = 32;
    localparam int CNT_W = 5;
    localparam int SYNC_W = 44;

    localparam logic [CNT_W-1:0] FRAME_COUNT = 5'h10;
    localparam logic [CNT_W-1:0] COUNT_MAX = 5'h1f;

    // ------------------------------------------------------------
    // control byte codes
    // ------------------------------------------------------------
    localparam logic [3:0] GRP_LOW_SEL = 4'h0;
    localparam logic [3:0] GRP_HIGH_SEL = 4'hf;
    localparam logic [3:0] CMD_DIAG = 4'h0;
    localparam logic [3:0] CMD_READ = 4'hc;
    localparam logic [3:0] CMD_ECHO = 4'ha;
    localparam logic [3:0] CMD_OR = 4'h3;
    localparam logic [3:0] CMD_AND = 4'hf;

    // ------------------------------------------------------------
    // diagnosis codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] DIAG_NORMAL = 2'h3;
    localparam logic [1:0] DIAG_OVERLOAD = 2'h2;
    localparam logic [1:0] DIAG_OPEN_LOAD = 2'h1;
    localparam logic [1:0] DIAG_SHORT_GND = 2'h0;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic OP_AND_RESET = 1'b0;

    typedef enum logic [1:0] {
        RESP_ZERO = 2'b00,
        RESP_DIAG = 2'b01,
        RESP_READ = 2'b10,
        RESP_ECHO = 2'b11
    } swcmd_resp_type;

endpackage

// file: swcmd_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin-level inputs.
 * Assumes every bit is a slow level relative to the clock; no bus
 * coherence is promised across bits.
 */
`timescale 1ns/1ps
module swcmd_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_stable;

    // first stage feeds only the second stage
    always_comb
    begin
        next_meta = d_i;
        next_stable = meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            meta <= '0;
            stable <= '0;
        end
        else
        begin
            meta <= next_meta;
            stable <= next_stable;
        end
    end

    assign q_o = stable;
endmodule

// file: swcmd_host.sv
/*
 * Host-side serial master model for the switch command decoder.
 * Assumes the device samples SI on the falling shift clock edge and moves
 * SO on the rising one; the shift clock stands low between frames.
 */
`timescale 1ns/1ps
module swcmd_host (
    input wire logic so_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o
);
    // ----------------------------------------------------------------
    // frame transfer, 64 ns shift clock period
    // ----------------------------------------------------------------
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    // si moves a short hold after each falling edge, since both pins share
    // one synchroniser delay; so is read just before the rise that advances it
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        cs_n_o = 1'b0;
        #200;
        for (int i = 15; i >= 0; i--)
        begin
            si_o = w[i];
            #24;
            r[i] = so_i;
            sclk_o = 1'b1;
            #32;
            sclk_o = 1'b0;
            #8;
        end
        #192;
        cs_n_o = 1'b1;
        // released data line must not keep its last level
        si_o = ~si_o;
        #200;
    endtask
endmodule

// file: tb.sv
/*
 * Self-checking bench for the switch command decoder.
 * Assumes the host model drives the serial pins and the bench owns
 * reset, the parallel inputs, the polarity pin and the diagnosis pairs.
 */
`timescale 1ns/1ps
module tb;
    import swcmd_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic prg = 1'b1;
    logic [7:0] par = 8'h05;
    logic [31:0] diag = 32'h4e1bd2c7;
    logic sclk;
    logic cs_n;
    logic si;
    logic [15:0] out;
    logic so;
    logic so_oe;
    logic op_and;
    int fail_count = 0;
    int checked = 0;
    logic [15:0] rx;
    logic [15:0] dat = 16'h0000;
    logic op = 1'b0;

    swcmd_decoder swcmd_decoder_i (.CLK_I(clk), .RESET_I(reset), .SCLK_I(sclk), .CS_N_I(cs_n),
        .SI_I(si), .PRG_I(prg), .PAR_IN_I(par), .DIAG_I(diag), .OUT_O(out), .SO_O(so),
        .SO_OE_O(so_oe), .OP_AND_O(op_and));
    swcmd_host swcmd_host_i (.so_i(so), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] exp_out(logic [15:0] d, logic [7:0] p, logic pol, logic o);
        logic [7:0] a;
        logic [15:0] q;
        a = pol ? p : ~p;
        q = d;
        for (int k = 0; k < 4; k++)
        begin
            q[k] = o ? (d[k] & a[k]) : (d[k] | a[k]);
            q[k+8] = o ? (d[k+8] & a[k+4]) : (d[k+8] | a[k+4]);
        end
        return q;
    endfunction

    function automatic logic [7:0] fault(logic [15:0] d);
        logic [7:0] f;
        for (int k = 0; k < 8; k++)
        begin
            f[k] = (d[2*k+1 -: 2] === 2'h3);
        end
        return f;
    endfunction

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task frame(input logic [15:0] w);
        @(negedge clk);
        fork
            swcmd_host_i.xfer(w, rx);
            begin
                #300;
                chk("oe on", 16'h0001, {15'h0, so_oe});
            end
        join
        @(negedge clk);
        chk("oe off", 16'h0000, {15'h0, so_oe});
    endtask

    task outs();
        chk("out", exp_out(dat, par, prg, op), out);
        chk("op_and", {15'h0, op}, {15'h0, op_and});
    endtask

    task end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task do_reset();
        @(negedge clk);
        reset = 1'b1;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset();
        chk("out rst", exp_out(DATA_RESET, par, prg, OP_AND_RESET), out);
        chk("op rst", 16'h0000, {15'h0, op_and});
        chk("oe rst", 16'h0000, {15'h0, so_oe});
    endtask

    task t_diag();
        frame(16'h00a5);
        outs();
        frame(16'h0f5a);
        chk("diag lo", diag[15:0], rx);
        outs();
    endtask

    task t_or_and();
        frame(16'h3090);
        chk("diag hi", diag[31:16], rx);
        dat[7:0] = 8'h90;
        outs();
        frame(16'hff31);
        chk("or diag", diag[15:0], rx);
        dat[15:8] = 8'h31;
        op = 1'b1;
        outs();
        par = 8'h3c;
        #50;
        outs();
    endtask

    task t_read();
        frame(16'hc0ff);
        chk("and diag", diag[31:16], rx);
        outs();
        frame(16'h0000);
        chk("readback", {par, fault(diag[15:0])}, rx);
        frame(16'hcf00);
        frame(16'h0000);
        chk("readback hi", {par, fault(diag[31:16])}, rx);
        outs();
    endtask

    task t_echo();
        frame(16'ha0ff);
        chk("pre echo", diag[15:0], rx);
        frame(16'h3fc3);
        chk("echo", 16'h3fc3, rx);
        outs();
        frame(16'h0000);
        chk("post echo", WORD_ZERO, rx);
    endtask

    task t_undef();
        frame(16'h70f0);
        chk("undef pre", diag[15:0], rx);
        outs();
        frame(16'h3500);
        chk("undef", WORD_ZERO, rx);
        outs();
        frame(16'h0000);
        chk("bad group", WORD_ZERO, rx);
    endtask

    task t_prg();
        prg = 1'b0;
        frame(16'h3f0f);
        dat[15:8] = 8'h0f;
        op = 1'b0;
        outs();
    endtask

    task t_mid_reset();
        frame(16'hf0ff);
        dat[7:0] = 8'hff;
        op = 1'b1;
        outs();
        do_reset();
        dat = DATA_RESET;
        op = 1'b0;
        outs();
        frame(16'h0000);
        chk("rst resp", WORD_ZERO, rx);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_diag();
        t_or_and();
        t_read();
        t_echo();
        t_undef();
        t_prg();
        t_mid_reset();
        end_sim();
    end

    // frames use fixed delays, so a hang can only come from the simulator
    initial
    begin
        #400000;
        fail_count++;
        end_sim();
    end
endmodule
